// [hw/clock_calendar.sv]
// pointer window access front end of the clock calendar
// Operation
// - time pointer in clock config bits 9:8
// - time pointer maps pairs min/sec through year
// - time upper write with write enable set steps pointer down, floor 00
// - alarm pointer in alarm config bits 9:8
// - alarm pointer maps pairs, 11 selects nothing
// - alarm upper write steps pointer down, floor 00
// - any alarm window read steps pointer down
// - any time window read steps pointer down
// - lower byte write leaves pointer alone
// - time writes need write enable bit 13
// - enable settable only right after 55/aa key
`timescale 1ns/1ns
`include "rtc_window_cfg.svh"

module clock_calendar (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_b,
   input  wire rtc_window_pkg::bus_req_t bus,
   output logic [15:0]                  rdata,
   output logic                         timer_write_enable,
   output rtc_window_pkg::ptr_t         time_window_pointer,
   output rtc_window_pkg::ptr_t         alarm_window_pointer
);
   import rtc_window_pkg::*;

   // ------------------------------------------------------------
   // storage and decode
   // ------------------------------------------------------------
   logic [15:0] time_pair [4];       // pair 3 upper byte unused
   logic [15:0] alarm_pair [3];      // pointer 11 has no pair
   key_state_t  key_state;           // unlock sequence state
   logic [7:0]  open_cnt;            // cycles left in unlock window
   logic        key_window;          // set of write enable allowed
   logic        wr_cfg;              // write to clock config
   logic        wr_acfg;             // write to alarm config
   logic        wr_time;             // write to time window
   logic        wr_alarm;            // write to alarm window
   logic        wr_key;              // write to unlock key
   logic        rd_time;             // read of time window
   logic        rd_alarm;            // read of alarm window
   logic        time_upper_ok;       // accepted upper time write
   logic [15:0] time_sel;            // time window view
   logic [15:0] alarm_sel;           // alarm window view
   logic [15:0] next_rdata;          // read mux result

   // strobe decode
   assign wr_cfg   = bus.wr && bus.addr == `OFS_CLOCK_CONFIG;
   assign wr_acfg  = bus.wr && bus.addr == `OFS_ALARM_CONFIG;
   assign wr_time  = bus.wr && bus.addr == `OFS_TIME_WINDOW;
   assign wr_alarm = bus.wr && bus.addr == `OFS_ALARM_WINDOW;
   assign wr_key   = bus.wr && bus.addr == `OFS_UNLOCK_KEY;
   assign rd_time  = bus.rd && bus.addr == `OFS_TIME_WINDOW;
   assign rd_alarm = bus.rd && bus.addr == `OFS_ALARM_WINDOW;
   // state literal and window flag kept apart, the enum name would be hidden
   assign key_window = (key_state == key_open);

   // locked writes are dropped whole, pointer included
   assign time_upper_ok = wr_time && timer_write_enable && bus.be[`BE_UPPER];

   // step a pointer down, holding at zero
   function automatic ptr_t step_down(input ptr_t p);
      step_down = (p == 2'h0) ? 2'h0 : p - 2'h1;
   endfunction

   // ------------------------------------------------------------
   // window views
   // ------------------------------------------------------------
   // time pointer picks a pair; pair 3 upper byte reads zero
   always_comb begin
      time_sel = time_pair[time_window_pointer];
      if (time_window_pointer == 2'h3) begin
         time_sel[15:8] = 8'h00;
      end
   end

   // alarm pointer 11 maps onto nothing
   always_comb begin
      if (alarm_window_pointer == 2'h3) begin
         alarm_sel = 16'h0000;
      end else begin
         alarm_sel = alarm_pair[alarm_window_pointer];
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = 16'h0000;
      unique case (bus.addr)
         `OFS_CLOCK_CONFIG: begin
            next_rdata[`BIT_WRITE_ENABLE]    = timer_write_enable;
            next_rdata[`PTR_HI:`PTR_LO]      = time_window_pointer;
         end
         `OFS_TIME_WINDOW:  next_rdata = time_sel;
         `OFS_ALARM_CONFIG: next_rdata[`PTR_HI:`PTR_LO] = alarm_window_pointer;
         `OFS_ALARM_WINDOW: next_rdata = alarm_sel;
         default:           next_rdata = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // read data, valid only in the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `RST_DATA;
      end else if (bus.rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= `RST_DATA;
      end
   end

   // ------------------------------------------------------------
   // unlock key sequence
   // ------------------------------------------------------------
   // any other write breaks the sequence, so a stray store
   // between the two key bytes cannot open the lock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         key_state <= key_idle;
         open_cnt  <= 8'h00;
      end else begin
         unique case (key_state)
            key_idle: begin
               if (wr_key && bus.wdata[7:0] == `KEY_FIRST) begin
                  key_state <= key_half;
               end
            end
            key_half: begin
               if (wr_key && bus.wdata[7:0] == `KEY_SECOND) begin
                  key_state <= key_open;
                  open_cnt  <= 8'(`UNLOCK_CYCLES);
               end else if (bus.wr) begin
                  key_state <= key_idle;
               end
            end
            key_open: begin
               // window closes after one instruction cycle
               if (open_cnt <= 8'h01 || bus.wr) begin
                  key_state <= key_idle;
                  open_cnt  <= 8'h00;
               end else begin
                  open_cnt  <= open_cnt - 8'h01;
               end
            end
            // unused code, fall back to a closed lock
            default: begin
               key_state <= key_idle;
               open_cnt  <= 8'h00;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // timer write enable
   // ------------------------------------------------------------
   // clearing is always allowed; setting only in the key window
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_write_enable <= 1'b0;
      end else if (wr_cfg && bus.be[`BE_UPPER]) begin
         if (!bus.wdata[`BIT_WRITE_ENABLE]) begin
            timer_write_enable <= 1'b0;
         end else if (key_window) begin
            timer_write_enable <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // time window pointer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         time_window_pointer <= `RST_PTR;
      end else if (wr_cfg && bus.be[`BE_UPPER]) begin
         time_window_pointer <= bus.wdata[`PTR_HI:`PTR_LO];
      end else if (time_upper_ok) begin
         // lower-only writes never reach here
         time_window_pointer <= step_down(time_window_pointer);
      end else if (rd_time) begin
         // the core cannot tell a byte read from a word read
         time_window_pointer <= step_down(time_window_pointer);
      end
   end

   // ------------------------------------------------------------
   // alarm window pointer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm_window_pointer <= `RST_PTR;
      end else if (wr_acfg && bus.be[`BE_UPPER]) begin
         alarm_window_pointer <= bus.wdata[`PTR_HI:`PTR_LO];
      end else if (wr_alarm && bus.be[`BE_UPPER]) begin
         alarm_window_pointer <= step_down(alarm_window_pointer);
      end else if (rd_alarm) begin
         alarm_window_pointer <= step_down(alarm_window_pointer);
      end
   end

   // ------------------------------------------------------------
   // time value storage, guarded by the write enable
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            time_pair[i] <= `RST_PAIR;
         end
      end else if (wr_time && timer_write_enable) begin
         if (bus.be[`BE_UPPER] && time_window_pointer != 2'h3) begin
            time_pair[time_window_pointer][15:8] <= bus.wdata[15:8];
         end
         if (bus.be[`BE_LOWER]) begin
            time_pair[time_window_pointer][7:0] <= bus.wdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // alarm value storage
   // ------------------------------------------------------------
   // pointer 11 writes fall on no register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 3; i++) begin
            alarm_pair[i] <= `RST_PAIR;
         end
      end else if (wr_alarm && alarm_window_pointer != 2'h3) begin
         if (bus.be[`BE_UPPER]) begin
            alarm_pair[alarm_window_pointer][15:8] <= bus.wdata[15:8];
         end
         if (bus.be[`BE_LOWER]) begin
            alarm_pair[alarm_window_pointer][7:0] <= bus.wdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_time_upper_step;
      time_upper_ok |=> time_window_pointer == step_down($past(time_window_pointer));
   endproperty
   a_time_upper_step: assert property (p_time_upper_step)
      else $error("time pointer did not step on upper write");

   property p_time_lower_hold;
      wr_time && bus.be == 2'b01 |=> $stable(time_window_pointer);
   endproperty
   a_time_lower_hold: assert property (p_time_lower_hold)
      else $error("time pointer moved on lower write");

   property p_time_read_step;
      rd_time |=> time_window_pointer == step_down($past(time_window_pointer));
   endproperty
   a_time_read_step: assert property (p_time_read_step)
      else $error("time pointer did not step on read");

   property p_alarm_upper_step;
      wr_alarm && bus.be[1] |=> alarm_window_pointer == step_down($past(alarm_window_pointer));
   endproperty
   a_alarm_upper_step: assert property (p_alarm_upper_step)
      else $error("alarm pointer did not step on upper write");

   property p_alarm_read_step;
      rd_alarm |=> alarm_window_pointer == step_down($past(alarm_window_pointer));
   endproperty
   a_alarm_read_step: assert property (p_alarm_read_step)
      else $error("alarm pointer did not step on read");

   property p_locked_write;
      wr_time && !timer_write_enable |=> $stable(time_pair[0]) && $stable(time_pair[3])
         && $stable(time_pair[1]) && $stable(time_pair[2])
         && $stable(time_window_pointer);
   endproperty
   a_locked_write: assert property (p_locked_write)
      else $error("locked time write changed state");

   property p_enable_needs_key;
      $rose(timer_write_enable) |-> $past(key_window);
   endproperty
   a_enable_needs_key: assert property (p_enable_needs_key)
      else $error("write enable set outside key window");

   property p_time_view;
      rd_time |=> rdata == $past(time_sel);
   endproperty
   a_time_view: assert property (p_time_view)
      else $error("time window read data wrong");

   property p_alarm_idle;
      rd_alarm && alarm_window_pointer == 2'h3 |=> rdata == 16'h0000;
   endproperty
   a_alarm_idle: assert property (p_alarm_idle)
      else $error("alarm pointer 11 read not zero");

   property p_year_upper;
      rd_time && time_window_pointer == 2'h3 |=> rdata[15:8] == 8'h00;
   endproperty
   a_year_upper: assert property (p_year_upper)
      else $error("unused upper time byte not zero");

   // lower-only alarm writes must not move the pointer
   property p_alarm_lower_hold;
      wr_alarm && bus.be == 2'b01 |=> $stable(alarm_window_pointer);
   endproperty
   a_alarm_lower_hold: assert property (p_alarm_lower_hold)
      else $error("alarm pointer moved on lower write");

   // config write loads the time pointer from bits 9:8
   property p_time_cfg_load;
      wr_cfg && bus.be[`BE_UPPER] |=>
         time_window_pointer == $past(bus.wdata[`PTR_HI:`PTR_LO]);
   endproperty
   a_time_cfg_load: assert property (p_time_cfg_load)
      else $error("time pointer not loaded from config");

   // alarm config write loads the alarm pointer from bits 9:8
   property p_alarm_cfg_load;
      wr_acfg && bus.be[`BE_UPPER] |=>
         alarm_window_pointer == $past(bus.wdata[`PTR_HI:`PTR_LO]);
   endproperty
   a_alarm_cfg_load: assert property (p_alarm_cfg_load)
      else $error("alarm pointer not loaded from config");

   // the key window lasts a single cycle, a late set must miss it
   property p_key_window_short;
      key_window |=> !key_window;
   endproperty
   a_key_window_short: assert property (p_key_window_short)
      else $error("key window open longer than one cycle");

   // clearing the enable works at any time, no key needed
   property p_enable_clear;
      wr_cfg && bus.be[`BE_UPPER] && !bus.wdata[`BIT_WRITE_ENABLE] |=> !timer_write_enable;
   endproperty
   a_enable_clear: assert property (p_enable_clear)
      else $error("write enable not cleared by config write");

endmodule // clock_calendar

// [include/rtc_window_cfg.svh]
// constants of the clock-calendar window access block
`ifndef RTC_WINDOW_CFG_SVH
`define RTC_WINDOW_CFG_SVH

// ---------------------------------------------------------------
// register word offsets
// ---------------------------------------------------------------
`define OFS_CLOCK_CONFIG   4'h0
`define OFS_TIME_WINDOW    4'h1
`define OFS_ALARM_CONFIG   4'h2
`define OFS_ALARM_WINDOW   4'h3
`define OFS_UNLOCK_KEY     4'h4

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_WRITE_ENABLE   13
`define PTR_HI             9
`define PTR_LO             8
`define BE_UPPER           1
`define BE_LOWER           0

// ---------------------------------------------------------------
// reset values and key bytes
// ---------------------------------------------------------------
`define RST_PTR            2'h0
`define RST_PAIR           16'h0000
`define RST_DATA           16'h0000
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'haa

// ---------------------------------------------------------------
// timing: unlock window is one instruction cycle
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define UNLOCK_WINDOW_NS   50
`define UNLOCK_CYCLES      ((`UNLOCK_WINDOW_NS) / (`CLK_PERIOD_NS))

`endif

// [include/rtc_window_pkg.sv]
// types of the clock-calendar window access block
package rtc_window_pkg;

   // two-bit window pointer
   typedef logic [1:0] ptr_t;

   // one register bus request, same clock as the block
   typedef struct packed {
      logic [3:0]  addr;   // word offset
      logic [15:0] wdata;  // write data
      logic [1:0]  be;     // byte lanes of a write
      logic        wr;     // write strobe
      logic        rd;     // read strobe
   } bus_req_t;

   // unlock key sequence tracker
   typedef enum logic [1:0] {
      key_idle,
      key_half,
      key_open
   } key_state_t;

endpackage

// [tb/tb_top.sv]
// self-checking bench of the clock calendar window access front end
`timescale 1ns/1ns
`include "rtc_window_cfg.svh"

module tb_top;
   import rtc_window_pkg::*;

   // ---------------------------------------------------------------
   // signals and counters
   // ---------------------------------------------------------------
   logic        sys_clk;               // 20 MHz system clock
   logic        rst_b;                 // active low reset
   bus_req_t    bus;                   // register bus request
   logic [15:0] rdata;                 // read answer
   logic        timer_write_enable;    // enable mirror
   ptr_t        time_window_pointer;   // time pointer mirror
   ptr_t        alarm_window_pointer;  // alarm pointer mirror
   int          n_errors;              // mismatches seen
   int          num_checks;            // comparisons made

   clock_calendar DUT (
      .sys_clk              (sys_clk),
      .rst_b                (rst_b),
      .bus                  (bus),
      .rdata                (rdata),
      .timer_write_enable   (timer_write_enable),
      .time_window_pointer  (time_window_pointer),
      .alarm_window_pointer (alarm_window_pointer)
   );

   // ---------------------------------------------------------------
   // clock, reset and watchdog
   // ---------------------------------------------------------------
   // clock toggles every half period of 50 ns
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // whole sequence needs about a hundred cycles, so 2000 is ample
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_errors = n_errors + 1;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   // verdict and end of run
   task automatic end_of_test();
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one comparison, reported on mismatch
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one bus cycle, launched just after a rising edge
   task automatic drive(input logic [3:0] a, input logic [15:0] d, input logic [1:0] b,
                        input logic w, input logic r);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, be: b, wr: w, rd: r};
   endtask

   // quiet cycle, lets the previous request be taken
   task automatic idle();
      drive(4'h0, 16'h0000, 2'b00, 1'b0, 1'b0);
   endtask

   // write then settle one edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] b);
      drive(a, d, b, 1'b1, 1'b0);
      idle();
      #1;
   endtask

   // read, sample in the answer cycle, then check it falls back to zero
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      drive(a, 16'h0000, 2'b00, 1'b0, 1'b1);
      idle();
      #1;
      chk(rdata, exp, "read data");
      @(posedge sys_clk);
      #1;
      chk(rdata, 16'h0000, "read data after answer");
   endtask

   // pointer and enable mirrors against expectation
   task automatic state_chk(input logic [1:0] tp, input logic [1:0] ap, input logic en);
      chk({14'h0, time_window_pointer}, {14'h0, tp}, "time pointer");
      chk({14'h0, alarm_window_pointer}, {14'h0, ap}, "alarm pointer");
      chk({15'h0, timer_write_enable}, {15'h0, en}, "write enable");
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // locked write ignored, read still steps pointer
   task automatic t_locked();
      wr(`OFS_CLOCK_CONFIG, 16'h0300, 2'b11);
      state_chk(2'b11, 2'b00, 1'b0);
      wr(`OFS_TIME_WINDOW, 16'h1111, 2'b11);
      state_chk(2'b11, 2'b00, 1'b0);
      rd_chk(`OFS_TIME_WINDOW, 16'h0000);
      state_chk(2'b10, 2'b00, 1'b0);
      rd_chk(4'hf, 16'h0000);
   endtask

   // late set after the key misses its window, prompt set succeeds
   task automatic t_unlock();
      drive(`OFS_UNLOCK_KEY, 16'h0055, 2'b11, 1'b1, 1'b0);
      drive(`OFS_UNLOCK_KEY, 16'h00aa, 2'b11, 1'b1, 1'b0);
      idle();
      wr(`OFS_CLOCK_CONFIG, 16'h2300, 2'b11);
      state_chk(2'b11, 2'b00, 1'b0);
      // a stray write between the key bytes breaks the sequence
      drive(`OFS_UNLOCK_KEY, 16'h0055, 2'b11, 1'b1, 1'b0);
      drive(4'hf, 16'h0000, 2'b11, 1'b1, 1'b0);
      drive(`OFS_UNLOCK_KEY, 16'h00aa, 2'b11, 1'b1, 1'b0);
      wr(`OFS_CLOCK_CONFIG, 16'h2300, 2'b11);
      state_chk(2'b11, 2'b00, 1'b0);
      drive(`OFS_UNLOCK_KEY, 16'h0055, 2'b11, 1'b1, 1'b0);
      drive(`OFS_UNLOCK_KEY, 16'h00aa, 2'b11, 1'b1, 1'b0);
      wr(`OFS_CLOCK_CONFIG, 16'h2300, 2'b11);
      state_chk(2'b11, 2'b00, 1'b1);
   endtask

   // back-to-back writes walk the pointer down to its floor
   task automatic t_time_rw();
      drive(`OFS_TIME_WINDOW, 16'h0024, 2'b11, 1'b1, 1'b0);
      drive(`OFS_TIME_WINDOW, 16'h0315, 2'b11, 1'b1, 1'b0);
      drive(`OFS_TIME_WINDOW, 16'h0212, 2'b11, 1'b1, 1'b0);
      drive(`OFS_TIME_WINDOW, 16'h3045, 2'b11, 1'b1, 1'b0);
      wr(`OFS_TIME_WINDOW, 16'h3146, 2'b11);
      state_chk(2'b00, 2'b00, 1'b1);
      wr(`OFS_CLOCK_CONFIG, 16'h2300, 2'b11);
      wr(`OFS_TIME_WINDOW, 16'hff25, 2'b01);
      state_chk(2'b11, 2'b00, 1'b1);
      rd_chk(`OFS_TIME_WINDOW, 16'h0025);
      rd_chk(`OFS_TIME_WINDOW, 16'h0315);
      rd_chk(`OFS_TIME_WINDOW, 16'h0212);
      rd_chk(`OFS_TIME_WINDOW, 16'h3146);
      rd_chk(`OFS_TIME_WINDOW, 16'h3146);
      state_chk(2'b00, 2'b00, 1'b1);
      wr(`OFS_CLOCK_CONFIG, 16'h0000, 2'b11);
      wr(`OFS_TIME_WINDOW, 16'h0101, 2'b11);
      state_chk(2'b00, 2'b00, 1'b0);
      rd_chk(`OFS_TIME_WINDOW, 16'h3146);
   endtask

   // alarm window: empty pair, byte lanes, reads stepping down
   task automatic t_alarm();
      wr(`OFS_ALARM_CONFIG, 16'h0300, 2'b11);
      state_chk(2'b00, 2'b11, 1'b0);
      wr(`OFS_ALARM_WINDOW, 16'h7777, 2'b11);
      state_chk(2'b00, 2'b10, 1'b0);
      drive(`OFS_ALARM_WINDOW, 16'h1231, 2'b11, 1'b1, 1'b0);
      wr(`OFS_ALARM_WINDOW, 16'h0508, 2'b11);
      state_chk(2'b00, 2'b00, 1'b0);
      wr(`OFS_ALARM_WINDOW, 16'hee11, 2'b01);
      state_chk(2'b00, 2'b00, 1'b0);
      rd_chk(`OFS_ALARM_WINDOW, 16'h0011);
      wr(`OFS_ALARM_WINDOW, 16'h5930, 2'b11);
      state_chk(2'b00, 2'b00, 1'b0);
      wr(`OFS_ALARM_CONFIG, 16'h0300, 2'b11);
      rd_chk(`OFS_ALARM_WINDOW, 16'h0000);
      state_chk(2'b00, 2'b10, 1'b0);
      rd_chk(`OFS_ALARM_WINDOW, 16'h1231);
      rd_chk(`OFS_ALARM_WINDOW, 16'h0508);
      rd_chk(`OFS_ALARM_WINDOW, 16'h5930);
      state_chk(2'b00, 2'b00, 1'b0);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      n_errors   = 0;
      num_checks = 0;
      rst_b      = 1'b0;
      bus        = '0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      #1;
      state_chk(2'b00, 2'b00, 1'b0);
      chk(rdata, 16'h0000, "reset read data");
      t_locked();
      t_unlock();
      t_time_rw();
      t_alarm();
      end_of_test();
   end

endmodule // tb_top
